// [verilog/swhp_port.sv]
// Purpose: Host port logic for an open-drain single-wire memory button bus
// Assumes: Avalon-MM slave, byte address on avs_address_i, 20 MHz clock
// Notes:   Three port styles selectable by mode; aux supply controls included
//
// Behaviour
// - Writing zero to the bidirectional port bit pulls the bus strongly low.
// - Writing one releases the line so the external pull-up sets the level.
// - Reading the port bit returns the live line level, one high, zero low.
// - The bit must hold one, line released, before the line is sampled.
// - Programmable-direction output latch holds zero from power-up, so output drives low.
// - Programmable-direction bus output goes through the direction bit, inverted.
// - Programmable-direction bus input reads the pin level itself.
// - Fixed-direction output pin carries the complement of the bus bit.
// - Fixed-direction bus level is read from the dedicated input pin.
// - Once used as output, the fixed output pin stays output until reset.
// - Two extra outputs control the programming supply and strong pull-up, isolated.
// - Bit starts are spaced no closer than the full bus signalling rate.
`timescale 1ns/1ns
`default_nettype none

module swhp_port #(
	parameter int unsigned SLOT_CYC = swhp_pkg::SWHP_SLOT_CYC
) (
	input  wire logic        sys_clk_i,
	input  wire logic        nrst_i,
	input  wire logic [3:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire logic        owb_i,
	output logic             owb_o,
	output logic             owb_oe_o,
	output logic             fix_out_o,
	output logic             fix_out_oe_o,
	input  wire logic        fix_in_i,
	output logic             spu_en_o,
	output logic             prog_en_o
);
	import swhp_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	swhp_state_s s_r;
	swhp_state_s s_nxt;

	logic       live_level;
	logic       sel_ctrl;
	logic       sel_bus;
	logic       sel_dir;
	logic       sel_stat;
	logic       wr_hold;
	logic       wr_ok;
	logic       wbit;
	logic       new_low;
	logic       prog_req;
	logic       spu_req;
	swhp_mode_e mode_req;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	assign sel_ctrl = (avs_address_i == SWHP_OFF_CTRL);
	assign sel_bus  = (avs_address_i == SWHP_OFF_BUS);
	assign sel_dir  = (avs_address_i == SWHP_OFF_DIR);
	assign sel_stat = (avs_address_i == SWHP_OFF_STAT);
	assign wbit     = avs_writedata_i[SWHP_BUS_BIT];

	// Fixed mode reads the dedicated input, others the line itself
	assign live_level = (s_r.mode == SWHP_MODE_FIXED) ? s_r.fin_s2 : s_r.bus_s2;

	// A new low start waits out the remaining slot time
	assign new_low = avs_write_i && sel_bus && avs_byteenable_i[0] && !wbit && s_r.bus_bit;
	assign wr_hold = new_low && (s_r.slot_cnt != '0);
	assign wr_ok   = avs_write_i && !wr_hold;

	// Reads take one wait cycle so read data comes from a register
	assign avs_waitrequest_o = (avs_read_i && !s_r.rd_pend) || wr_hold;
	assign avs_readdata_o    = s_r.rdata;

	assign mode_req = swhp_mode_e'(avs_writedata_i[SWHP_CTRL_MODE_LSB +: $bits(swhp_mode_e)]);
	assign prog_req = avs_writedata_i[SWHP_CTRL_PROG_BIT];
	assign spu_req  = avs_writedata_i[SWHP_CTRL_SPU_BIT] && !prog_req;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;

		// Pin synchronisers
		s_nxt.bus_s1 = owb_i;
		s_nxt.bus_s2 = s_r.bus_s1;
		s_nxt.fin_s1 = fix_in_i;
		s_nxt.fin_s2 = s_r.fin_s1;

		// Output data latch stays low for every drive cycle
		s_nxt.pin_latch = SWHP_RST_PIN_LATCH;

		if (s_r.slot_cnt != '0) begin
			s_nxt.slot_cnt = s_r.slot_cnt - 1'b1;
		end

		if (wr_ok && avs_byteenable_i[0]) begin
			if (sel_ctrl) begin
				// Mode is frozen once the fixed output has been used
				if (!s_r.fix_lock && mode_req != SWHP_MODE_RSVD) begin
					s_nxt.mode = mode_req;
				end
				s_nxt.prog = prog_req;
				s_nxt.spu  = spu_req;
			end
			if (sel_bus) begin
				s_nxt.bus_bit = wbit;
				if (new_low) begin
					s_nxt.slot_cnt = SWHP_SLOT_W'(SLOT_CYC);
				end
				case (s_r.mode)
					SWHP_MODE_PDIR: begin
						s_nxt.dir_bit = !wbit;
					end
					SWHP_MODE_FIXED: begin
						s_nxt.fix_oe   = 1'b1;
						s_nxt.fix_lock = 1'b1;
					end
					default: begin
						s_nxt.dir_bit = s_r.dir_bit;
					end
				endcase
			end
		end

		// Pin drives, released while the programming supply is on
		case (s_nxt.mode)
			SWHP_MODE_BIDIR: begin
				s_nxt.drv_oe  = !s_nxt.bus_bit;
				s_nxt.fix_drv = 1'b0;
			end
			SWHP_MODE_PDIR: begin
				s_nxt.drv_oe  = s_nxt.dir_bit;
				s_nxt.fix_drv = 1'b0;
			end
			SWHP_MODE_FIXED: begin
				s_nxt.drv_oe  = 1'b0;
				s_nxt.fix_drv = !s_nxt.bus_bit;
			end
			default: begin
				s_nxt.drv_oe  = 1'b0;
				s_nxt.fix_drv = 1'b0;
			end
		endcase
		if (s_nxt.prog) begin
			s_nxt.drv_oe  = 1'b0;
			s_nxt.fix_drv = 1'b0;
		end

		// Register read path
		s_nxt.rd_pend = avs_read_i && !s_r.rd_pend;
		if (avs_read_i && !s_r.rd_pend) begin
			s_nxt.rdata = '0;
			if (sel_ctrl) begin
				s_nxt.rdata[SWHP_CTRL_MODE_LSB +: $bits(swhp_mode_e)] = s_r.mode;
				s_nxt.rdata[SWHP_CTRL_SPU_BIT]       = s_r.spu;
				s_nxt.rdata[SWHP_CTRL_PROG_BIT]      = s_r.prog;
			end
			if (sel_bus) begin
				s_nxt.rdata[SWHP_BUS_BIT] = live_level;
			end
			if (sel_dir) begin
				s_nxt.rdata[SWHP_DIR_BIT] = s_r.dir_bit;
			end
			if (sel_stat) begin
				s_nxt.rdata[SWHP_STAT_LEVEL] = live_level;
				s_nxt.rdata[SWHP_STAT_REL]   = s_r.bus_bit;
				s_nxt.rdata[SWHP_STAT_LOCK]  = s_r.fix_lock;
				s_nxt.rdata[SWHP_STAT_BUSY]  = (s_r.slot_cnt != '0);
			end
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_r.mode      <= SWHP_MODE_BIDIR;
			s_r.spu       <= 1'b0;
			s_r.prog      <= 1'b0;
			s_r.bus_bit   <= SWHP_RST_BUS_BIT;
			s_r.dir_bit   <= SWHP_RST_DIR_BIT;
			s_r.pin_latch <= SWHP_RST_PIN_LATCH;
			s_r.drv_oe    <= 1'b0;
			s_r.fix_drv   <= 1'b0;
			s_r.fix_oe    <= 1'b0;
			s_r.fix_lock  <= 1'b0;
			s_r.slot_cnt  <= '0;
			s_r.bus_s1    <= 1'b0;
			s_r.bus_s2    <= 1'b0;
			s_r.fin_s1    <= 1'b0;
			s_r.fin_s2    <= 1'b0;
			s_r.rd_pend   <= 1'b0;
			s_r.rdata     <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ------------------------------------------------------------
	// Pins
	// ------------------------------------------------------------
	assign owb_o        = s_r.pin_latch;
	assign owb_oe_o     = s_r.drv_oe;
	assign fix_out_o    = s_r.fix_drv;
	assign fix_out_oe_o = s_r.fix_oe;
	assign spu_en_o     = s_r.spu;
	assign prog_en_o    = s_r.prog;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence bus_wr_zero;
		avs_write_i && !avs_waitrequest_o && sel_bus && avs_byteenable_i[0] && !wbit && !prog_en_o;
	endsequence

	sequence bus_wr_one;
		avs_write_i && !avs_waitrequest_o && sel_bus && avs_byteenable_i[0] && wbit;
	endsequence

	sequence bus_rd_done;
		avs_read_i && !avs_waitrequest_o && sel_bus;
	endsequence

	sequence ctrl_wr_done;
		avs_write_i && !avs_waitrequest_o && sel_ctrl && avs_byteenable_i[0];
	endsequence

	sequence stat_rd_done;
		avs_read_i && !avs_waitrequest_o && sel_stat;
	endsequence

	a_bidir_pull_low: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(bus_wr_zero and (s_r.mode == SWHP_MODE_BIDIR) and !(sel_ctrl)) |=> owb_oe_o && !owb_o)
		else $error("bidir zero write did not pull the line low");

	a_bidir_release: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(bus_wr_one and (s_r.mode != SWHP_MODE_PDIR)) |=> !owb_oe_o)
		else $error("one write did not release the line");

	a_read_live_level: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		bus_rd_done |-> avs_readdata_o[SWHP_BUS_BIT] == $past(live_level))
		else $error("bus read does not show the synchronised level");

	a_drive_when_held: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(owb_oe_o && s_r.mode == SWHP_MODE_BIDIR) |-> !s_r.bus_bit)
		else $error("line driven although the port bit holds one");

	a_latch_stays_low: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		!owb_o)
		else $error("output data latch not held at zero");

	a_pdir_inverted: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(bus_wr_zero and (s_r.mode == SWHP_MODE_PDIR)) |=> s_r.dir_bit ##0 owb_oe_o)
		else $error("direction bit not set by a zero bus bit");

	a_fixed_complement: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(bus_wr_zero and (s_r.mode == SWHP_MODE_FIXED)) |=> fix_out_o && fix_out_oe_o && !owb_oe_o)
		else $error("fixed output not complemented");

	a_fixed_read_pin: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(bus_rd_done and (s_r.mode == SWHP_MODE_FIXED) and $stable(s_r.mode))
		|-> avs_readdata_o[SWHP_BUS_BIT] == $past(s_r.fin_s2))
		else $error("fixed mode read not from the input pin");

	a_fixed_stays_out: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		$rose(fix_out_oe_o) |=> fix_out_oe_o [*8] ##0 (s_r.mode == SWHP_MODE_FIXED))
		else $error("fixed output pin returned to input");

	a_prog_isolated: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		prog_en_o |-> !spu_en_o && !owb_oe_o && !fix_out_o)
		else $error("programming supply not isolated");

	a_slot_spacing: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		$fell(s_r.bus_bit) |-> ($past(s_r.slot_cnt) == '0) && (s_r.slot_cnt == SWHP_SLOT_W'(SLOT_CYC)))
		else $error("bit start closer than one slot");

	a_slot_hold: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(new_low && s_r.slot_cnt != '0) |-> avs_waitrequest_o ##1 s_r.bus_bit)
		else $error("early bit start not held off");

	a_aux_off_idle: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(!$past(avs_write_i) && $past(!spu_en_o) && $past(!prog_en_o)) |-> !spu_en_o && !prog_en_o)
		else $error("auxiliary supply switched on without a write");

	// ------------------------------------------------------------
	// Reset, control, status, bus port and slot timing checks
	// ------------------------------------------------------------

	a_reset_released: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		$rose(nrst_i) |-> !owb_oe_o && !fix_out_oe_o && !fix_out_o && !spu_en_o && !prog_en_o)
		else $error("port not released after reset");

	a_prog_wins: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(ctrl_wr_done and prog_req) |=> prog_en_o && !spu_en_o)
		else $error("strong pull-up on together with programming supply");

	a_mode_frozen: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		s_r.fix_lock |=> s_r.fix_lock && $stable(s_r.mode))
		else $error("port style changed after the fixed output was used");

	a_pdir_read_pin: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(bus_rd_done and (s_r.mode == SWHP_MODE_PDIR) and $stable(s_r.mode))
		|-> avs_readdata_o[SWHP_BUS_BIT] == $past(s_r.bus_s2))
		else $error("programmable direction read not from the pin level");

	a_pdir_release: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(bus_wr_one and (s_r.mode == SWHP_MODE_PDIR)) |=> !s_r.dir_bit && !owb_oe_o)
		else $error("direction bit not cleared by a one bus bit");

	a_fixed_release: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(bus_wr_one and (s_r.mode == SWHP_MODE_FIXED)) |=> !fix_out_o && fix_out_oe_o)
		else $error("fixed output not released by a one bus bit");

	a_fixed_no_bidir: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(s_r.mode == SWHP_MODE_FIXED) |-> !owb_oe_o)
		else $error("bidirectional pin driven in fixed mode");

	a_stat_released: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		stat_rd_done |-> avs_readdata_o[SWHP_STAT_REL] == $past(s_r.bus_bit))
		else $error("status does not show the released port bit");

	a_slot_count_down: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(s_r.slot_cnt != '0) |=> s_r.slot_cnt == $past(s_r.slot_cnt) - 1'b1)
		else $error("slot counter not counting down");

	a_be_ignored: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(avs_write_i && sel_bus && !avs_byteenable_i[0]) |=> $stable(s_r.bus_bit))
		else $error("bus bit changed by a write without byte enable");

endmodule

`default_nettype wire

// [verilog/swhp_pkg.sv]
// Purpose: Constants and types for the single-wire host port
// Assumes: 20 MHz system clock, Avalon-MM register access
// Notes:   Register offsets are byte addresses, one 32-bit word each
package swhp_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned SWHP_CLK_HZ       = 20_000_000;
	localparam int unsigned SWHP_BIT_RATE_BPS = 16_400;
	// Least spacing between bit starts, rounded up to whole cycles
	localparam int unsigned SWHP_SLOT_CYC     = (SWHP_CLK_HZ + SWHP_BIT_RATE_BPS - 1) / SWHP_BIT_RATE_BPS;
	localparam int unsigned SWHP_SLOT_W       = 16;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [3:0] SWHP_OFF_CTRL = 4'h0;
	localparam logic [3:0] SWHP_OFF_BUS  = 4'h4;
	localparam logic [3:0] SWHP_OFF_DIR  = 4'h8;
	localparam logic [3:0] SWHP_OFF_STAT = 4'hc;

	localparam int unsigned SWHP_CTRL_MODE_LSB = 0;
	localparam int unsigned SWHP_CTRL_SPU_BIT  = 2;
	localparam int unsigned SWHP_CTRL_PROG_BIT = 3;
	localparam int unsigned SWHP_BUS_BIT       = 0;
	localparam int unsigned SWHP_DIR_BIT       = 0;
	localparam int unsigned SWHP_STAT_LEVEL    = 0;
	localparam int unsigned SWHP_STAT_REL      = 1;
	localparam int unsigned SWHP_STAT_LOCK     = 2;
	localparam int unsigned SWHP_STAT_BUSY     = 3;

	localparam logic        SWHP_RST_BUS_BIT   = 1'b1;
	localparam logic        SWHP_RST_DIR_BIT   = 1'b0;
	localparam logic        SWHP_RST_PIN_LATCH = 1'b0;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SWHP_MODE_BIDIR = 2'b00,
		SWHP_MODE_PDIR  = 2'b01,
		SWHP_MODE_FIXED = 2'b10,
		SWHP_MODE_RSVD  = 2'b11
	} swhp_mode_e;

	typedef struct packed {
		swhp_mode_e             mode;
		logic                   spu;
		logic                   prog;
		logic                   bus_bit;
		logic                   dir_bit;
		logic                   pin_latch;
		logic                   drv_oe;
		logic                   fix_drv;
		logic                   fix_oe;
		logic                   fix_lock;
		logic [SWHP_SLOT_W-1:0] slot_cnt;
		logic                   bus_s1;
		logic                   bus_s2;
		logic                   fin_s1;
		logic                   fin_s2;
		logic                   rd_pend;
		logic [31:0]            rdata;
	} swhp_state_s;

endpackage

// [tb/swhp_button_model.sv]
// Purpose: Memory button and pulled-up bus line seen from the host port
// Assumes: Host only ever pulls low; pull-up sets the idle level
// Notes:   Fixed output pin acts through an inverting open-drain transistor
`timescale 1ns/1ns
`default_nettype none

module swhp_button_model (
	input  wire logic host_drv_i,
	input  wire logic host_oe_i,
	input  wire logic fix_out_i,
	input  wire logic fix_oe_i,
	input  wire logic pull_i,
	output logic      line_o
);
	logic host_low;

	// Wired-and of every party that can pull the line
	assign host_low = (host_oe_i & ~host_drv_i) | (fix_oe_i & fix_out_i);
	assign line_o   = ~(host_low | pull_i);
endmodule

`default_nettype wire

// [tb/single_wire_host_port_tb_top.sv]
// Purpose: Self-checking bench for the single-wire host port
// Assumes: Avalon-MM master, slot counter shortened to 8 cycles
// Notes:   Level reads wait out the two-stage input synchroniser
`timescale 1ns/1ns
`default_nettype none

module single_wire_host_port_tb_top;
	import swhp_pkg::*;

	localparam int unsigned SLOT = 8;

	logic        sys_clk_i = 1'b0;
	logic        nrst_i    = 1'b0;
	logic [3:0]  avs_address_i = 4'h0;
	logic        avs_read_i = 1'b0;
	logic        avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [3:0]  avs_byteenable_i = 4'hf;
	logic [31:0] avs_readdata_o;
	logic        avs_waitrequest_o;
	logic        owb_i, owb_o, owb_oe_o, fix_out_o, fix_out_oe_o, fix_in_i, spu_en_o, prog_en_o;
	logic        line, pull = 1'b0;
	int          err_count = 0;
	int          total_checks = 0;
	int          cyc = 0;
	int          acc_cyc;
	int          t0;

	swhp_port #(.SLOT_CYC(SLOT)) uut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .owb_i(owb_i), .owb_o(owb_o), .owb_oe_o(owb_oe_o),
		.fix_out_o(fix_out_o), .fix_out_oe_o(fix_out_oe_o), .fix_in_i(fix_in_i),
		.spu_en_o(spu_en_o), .prog_en_o(prog_en_o));

	swhp_button_model btn (.host_drv_i(owb_o), .host_oe_i(owb_oe_o), .fix_out_i(fix_out_o),
		.fix_oe_i(fix_out_oe_o), .pull_i(pull), .line_o(line));

	// Bidir pin floats high once the bus is on the dedicated fixed pins
	assign owb_i    = fix_out_oe_o ? 1'b1 : line;
	assign fix_in_i = line;

	initial begin
		forever #25 sys_clk_i = ~sys_clk_i;
	end

	always @(posedge sys_clk_i) cyc <= cyc + 1;

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task finish_test;
		$display("Checks %0d, mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
		output logic [31:0] q);
		@(posedge sys_clk_i);
		avs_address_i    <= a;
		avs_writedata_i  <= d;
		avs_byteenable_i <= be;
		avs_write_i      <= wr;
		avs_read_i       <= ~wr;
		do begin
			@(posedge sys_clk_i);
		end while (avs_waitrequest_o !== 1'b0);
		q = avs_readdata_o;
		acc_cyc = cyc;
		avs_write_i <= 1'b0;
		avs_read_i  <= 1'b0;
	endtask

	task wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, 4'hf, q);
		@(negedge sys_clk_i);
	endtask

	task rchk(input logic [3:0] a, input logic [31:0] exp);
		logic [31:0] q;
		repeat (3) @(posedge sys_clk_i);
		bus(1'b0, a, 32'h0, 4'hf, q);
		chk(q, exp);
	endtask

	task do_reset;
		@(posedge sys_clk_i) nrst_i <= 1'b0;
		repeat (16) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		@(negedge sys_clk_i);
		chk(32'({owb_oe_o, fix_out_oe_o, fix_out_o, spu_en_o, prog_en_o}), 32'h0);
	endtask

	task t_reset;
		do_reset();
		rchk(SWHP_OFF_STAT, 32'h3);
		rchk(4'h1, 32'h0);
	endtask

	task t_bidir;
		logic [31:0] q;
		bus(1'b1, SWHP_OFF_BUS, 32'h0, 4'h0, q);
		@(negedge sys_clk_i);
		chk(32'(owb_oe_o), 32'h0);
		wr(SWHP_OFF_BUS, 32'h0);
		chk(32'({owb_oe_o, owb_o}), 32'h2);
		rchk(SWHP_OFF_BUS, 32'h0);
		wr(SWHP_OFF_BUS, 32'h1);
		chk(32'(owb_oe_o), 32'h0);
		rchk(SWHP_OFF_BUS, 32'h1);
		@(posedge sys_clk_i) pull <= 1'b1;
		rchk(SWHP_OFF_BUS, 32'h0);
		@(posedge sys_clk_i) pull <= 1'b0;
	endtask

	task t_rate;
		wr(SWHP_OFF_BUS, 32'h0);
		t0 = acc_cyc;
		wr(SWHP_OFF_BUS, 32'h1);
		wr(SWHP_OFF_BUS, 32'h0);
		chk(32'(acc_cyc - t0 >= SLOT), 32'h1);
		wr(SWHP_OFF_BUS, 32'h1);
		rchk(SWHP_OFF_STAT, 32'hb);
	endtask

	task t_pdir;
		wr(SWHP_OFF_CTRL, 32'h1);
		wr(SWHP_OFF_BUS, 32'h0);
		chk(32'({owb_oe_o, owb_o}), 32'h2);
		rchk(SWHP_OFF_DIR, 32'h1);
		wr(SWHP_OFF_BUS, 32'h1);
		chk(32'(owb_oe_o), 32'h0);
		rchk(SWHP_OFF_DIR, 32'h0);
		rchk(SWHP_OFF_BUS, 32'h1);
		@(posedge sys_clk_i) pull <= 1'b1;
		rchk(SWHP_OFF_BUS, 32'h0);
		@(posedge sys_clk_i) pull <= 1'b0;
	endtask

	task t_fixed;
		wr(SWHP_OFF_CTRL, 32'h2);
		wr(SWHP_OFF_BUS, 32'h0);
		chk(32'({fix_out_o, fix_out_oe_o, owb_oe_o}), 32'h6);
		rchk(SWHP_OFF_BUS, 32'h0);
		wr(SWHP_OFF_CTRL, 32'h0);
		wr(SWHP_OFF_BUS, 32'h1);
		chk(32'({fix_out_o, fix_out_oe_o}), 32'h1);
		rchk(SWHP_OFF_STAT, 32'h7);
		rchk(SWHP_OFF_CTRL, 32'h2);
		do_reset();
	endtask

	task t_aux;
		wr(SWHP_OFF_CTRL, 32'h4);
		chk(32'({spu_en_o, prog_en_o}), 32'h2);
		wr(SWHP_OFF_CTRL, 32'hc);
		chk(32'({spu_en_o, prog_en_o}), 32'h1);
		wr(SWHP_OFF_BUS, 32'h0);
		chk(32'(owb_oe_o), 32'h0);
		wr(SWHP_OFF_CTRL, 32'h0);
		wr(SWHP_OFF_BUS, 32'h1);
		chk(32'({spu_en_o, prog_en_o, owb_oe_o}), 32'h0);
	endtask

	initial begin
		t_reset();
		t_bidir();
		t_rate();
		t_pdir();
		t_fixed();
		t_aux();
		finish_test();
	end

	initial begin
		#400000;
		err_count++;
		finish_test();
	end
endmodule

`default_nettype wire
